// ---- rtl/adcb_pkg.sv ----
// Constants shared by the converter digital back end
package adcb_pkg;
  localparam int NCH       = 4;
  localparam int DW        = 11;
  localparam int RW        = 12;
  localparam int WORD_W    = NCH * DW;
  localparam int PAIRS     = WORD_W / 2;
  localparam int RAW_BUS_W = NCH * RW;
  localparam int FIFO_DEPTH = 8;
  localparam int AW        = 8;

  // Register byte offsets
  localparam logic [AW-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [AW-1:0] ADDR_GAIN   = 8'h04;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h08;
  localparam logic [AW-1:0] ADDR_EST0   = 8'h0C;
  localparam logic [AW-1:0] ADDR_EST3   = 8'h18;

  // Control and status register fields
  localparam int CTRL_MODE1    = 0;
  localparam int CTRL_MODE2    = 1;
  localparam int CTRL_DC_EN    = 2;
  localparam int CTRL_DC_HOLD  = 3;
  localparam int CTRL_TC_LSB   = 4;
  localparam int CTRL_PARALLEL = 8;
  localparam int CTRL_FMT_LSB  = 9;
  localparam int CTRL_DRIVE2X  = 13;
  localparam int CTRL_HALT     = 14;
  localparam int STAT_OVF      = 0;
  localparam int STAT_LVL_LSB  = 1;

  // Fine gain, Q8 multipliers for 0 dB to 6 dB in 0.5 dB steps
  localparam int GAIN_SHIFT = 8;
  localparam logic [3:0] GAIN_CODE_MAX = 4'hC;
  localparam logic signed [10:0] GAIN_UNITY = 11'h100;
  localparam logic [9:0] GAIN_Q [0:12] = '{10'h100, 10'h10F, 10'h11F, 10'h130, 10'h142,
    10'h155, 10'h16A, 10'h17F, 10'h196, 10'h1AE, 10'h1C8, 10'h1E3, 10'h1FF};

  // Offset loop: time constant is 2^(TC_BASE_SHIFT + code) cycles
  localparam int ACC_W = 44;
  localparam int ACC_FRAC = 31;
  localparam logic [5:0] TC_BASE_SHIFT = 6'h14;
  localparam logic [3:0] TC_CODE_MAX = 4'hB;
  localparam int DC_LIMIT_MV = 10;
  localparam int FS_MV = 2000;
  localparam logic signed [RW-1:0] DC_LIMIT_CODE = RW'(DC_LIMIT_MV * 2048 / FS_MV);

  // Output saturation in two's complement
  localparam logic signed [15:0] SAT_POS = 16'sh03FF;
  localparam logic signed [15:0] SAT_NEG = -16'sh0400;
  localparam logic [DW-1:0] CODE_POS = 11'h3FF;
  localparam logic [DW-1:0] CODE_NEG = 11'h400;

  // Output clock phases, four pclk per word
  localparam logic [1:0] PH_LOAD = 2'h0;
  localparam logic [1:0] PH_MID  = 2'h2;
endpackage : adcb_pkg

// ---- rtl/adcb_backend.sv ----
// Converter digital back end: offset loop, fine gain, formatting, output pins
`timescale 1ns/1ps

module adcb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // Fill side
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  // Drain side
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (level != (PW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge pclk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : PW'(wr_ptr + 1'b1);
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : PW'(rd_ptr + 1'b1);
      end
      if (push && !pop)
      begin
        level <= (PW+1)'(level + 1'b1);
      end
      else if (pop && !push)
      begin
        level <= (PW+1)'(level - 1'b1);
      end
    end
  end
endmodule : adcb_fifo

// Operation
// - Fine gain 0 to 6 dB, half-dB steps
// - Gain off at reset; both mode bits enable
// - Gain step scales full-scale range proportionally
// - Offset loop estimates and subtracts each sample
// - Hold stops estimator, last estimate still applied
// - Offset loop off at reset, needs mode bits
// - Time code sets 2^(20+code) cycles, reserved clamp
// - 11-bit sample per channel, shared output clock
// - Register bit selects DDR or parallel pins
// - DDR carries two bits per pair
// - Parallel drives each bit on own pin
// - Per-channel bit selects twos complement/offset binary
// - Positive overdrive clips to maximum code
// - Negative overdrive clips to minimum code
module adcb_backend (
  // APB slave
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [adcb_pkg::AW-1:0]          paddr,
  input  wire logic [31:0]                      pwdata,
  output logic [31:0]                           prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  // Converter core
  input  wire logic                             sample_clock,
  input  wire logic [adcb_pkg::RAW_BUS_W-1:0]   core_sample,
  // Output pins
  output logic [adcb_pkg::WORD_W-1:0]           out_data,
  output logic                                  sample_output_clock,
  output logic                                  output_parallel,
  output logic                                  diff_clock_drive_double
);
  import adcb_pkg::*;

  logic [1:0]            digital_mode;
  logic                  dc_loop_enable;
  logic                  dc_loop_hold;
  logic [3:0]            dc_loop_time_code;
  logic                  parallel_mode;
  logic [NCH-1:0]        channel_code_format;
  logic                  output_halt;
  logic [3:0]            gain_code;
  logic                  overflow;
  logic                  smp_s1;
  logic                  smp_s2;
  logic                  smp_s3;
  logic [RAW_BUS_W-1:0]  raw_s1;
  logic [RAW_BUS_W-1:0]  raw_s2;
  logic                  tick;
  logic                  digital_on;
  logic                  loop_run;
  logic [5:0]            loop_shift;
  logic signed [10:0]    gain_mult;
  logic [WORD_W-1:0]     next_word;
  logic [WORD_W-1:0]     proc_word;
  logic                  proc_valid;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic [WORD_W-1:0]     fifo_out_data;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  logic                  pop;
  logic [1:0]            phase;
  logic [WORD_W-1:0]     cur_word;
  logic [WORD_W-1:0]     word_sel;
  logic [WORD_W-1:0]     next_out_data;
  logic                  pin_parallel;
  logic [RW-1:0]         est_bus [0:NCH-1];
  logic                  wr_en;
  logic                  setup;
  logic [31:0]           next_prdata;
  logic                  next_pslverr;

  // Sampling clock and core data pass two flops before use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      smp_s1 <= 1'b0;
      smp_s2 <= 1'b0;
      smp_s3 <= 1'b0;
      raw_s1 <= '0;
      raw_s2 <= '0;
    end
    else
    begin
      smp_s1 <= sample_clock;
      smp_s2 <= smp_s1;
      smp_s3 <= smp_s2;
      raw_s1 <= core_sample;
      raw_s2 <= raw_s1;
    end
  end

  assign tick = smp_s2 & ~smp_s3;

  assign digital_on = &digital_mode;
  assign loop_run   = digital_on & dc_loop_enable;
  assign loop_shift = TC_BASE_SHIFT + 6'((dc_loop_time_code > TC_CODE_MAX) ?
                      TC_CODE_MAX : dc_loop_time_code);
  assign gain_mult  = digital_on ?
                      $signed({1'b0, GAIN_Q[(gain_code > GAIN_CODE_MAX) ?
                      GAIN_CODE_MAX : gain_code]}) : GAIN_UNITY;

  // Per-channel offset loop, gain, saturation and formatting
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    logic signed [ACC_W-1:0] acc;
    logic signed [RW-1:0]    x;
    logic signed [RW-1:0]    est;
    logic signed [RW-1:0]    est_lim;
    logic signed [ACC_W:0]   diff;
    logic signed [RW:0]      corr;
    logic signed [23:0]      prod;
    logic signed [15:0]      scaled;
    logic [DW-1:0]           sat;

    assign x    = $signed(raw_s2[c*RW +: RW]);
    assign est  = acc[ACC_FRAC +: RW];
    // Estimate is bounded to the correctable range
    assign est_lim = (est > DC_LIMIT_CODE) ? DC_LIMIT_CODE :
                     (est < -DC_LIMIT_CODE) ? -DC_LIMIT_CODE : est;
    assign diff = ((ACC_W+1)'(x) <<< ACC_FRAC) - (ACC_W+1)'(acc);
    assign corr = loop_run ? ((RW+1)'(x) - (RW+1)'(est_lim)) : (RW+1)'(x);
    assign prod   = corr * gain_mult;
    assign scaled = 16'(prod >>> GAIN_SHIFT);
    assign sat    = (scaled > SAT_POS) ? CODE_POS :
                    (scaled < SAT_NEG) ? CODE_NEG : scaled[DW-1:0];
    assign next_word[c*DW +: DW] = channel_code_format[c] ?
                                   {~sat[DW-1], sat[DW-2:0]} : sat;
    assign est_bus[c] = est_lim;

    // Estimator advances only on sample ticks and freezes on hold
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        acc <= '0;
      end
      else if (tick && loop_run && !dc_loop_hold)
      begin
        acc <= ACC_W'(acc + ACC_W'(diff >>> loop_shift));
      end
    end
  end

  // Word is computed in the tick cycle from one settings snapshot
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      proc_word  <= '0;
      proc_valid <= 1'b0;
    end
    else
    begin
      proc_valid <= tick;
      if (tick)
      begin
        proc_word <= next_word;
      end
    end
  end

  // A full buffer drops the sample and flags it rather than stall the core
  adcb_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (proc_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (proc_word),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // Output serializer, one word per four pclk
  assign pop      = (phase == PH_LOAD) & fifo_out_valid & ~output_halt;
  assign word_sel = pop ? fifo_out_data : cur_word;
  // A mode write mid-word must not reshape the second half of that word
  assign pin_parallel = (phase == PH_LOAD) ? parallel_mode : output_parallel;

  for (genvar p = 0; p < WORD_W; p++)
  begin : g_pin
    if (p < PAIRS)
    begin : g_pair
      assign next_out_data[p] = pin_parallel ? word_sel[p] :
                                (phase == PH_MID) ? cur_word[2*p+1] : word_sel[2*p];
    end
    else
    begin : g_upper
      assign next_out_data[p] = pin_parallel & word_sel[p];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase               <= PH_LOAD;
      cur_word            <= '0;
      out_data            <= '0;
      sample_output_clock <= 1'b0;
      output_parallel     <= 1'b0;
    end
    else
    begin
      phase <= 2'(phase + 2'h1);
      if (phase == PH_LOAD)
      begin
        cur_word            <= word_sel;
        out_data            <= next_out_data;
        output_parallel     <= parallel_mode;
        // DDR rises with even bits; parallel rises mid-word for capture
        sample_output_clock <= ~parallel_mode;
      end
      else if (phase == PH_MID)
      begin
        sample_output_clock <= output_parallel;
        if (!output_parallel)
        begin
          out_data <= next_out_data;
        end
      end
    end
  end

  // APB slave: one wait-free access, pready registered in setup
  assign setup = psel & ~penable & ~pready;
  assign wr_en = psel & penable & pready & pwrite;

  always_comb
  begin
    next_prdata  = '0;
    next_pslverr = 1'b0;
    if (paddr == ADDR_CTRL)
    begin
      next_prdata[CTRL_MODE1]                 = digital_mode[0];
      next_prdata[CTRL_MODE2]                 = digital_mode[1];
      next_prdata[CTRL_DC_EN]                 = dc_loop_enable;
      next_prdata[CTRL_DC_HOLD]               = dc_loop_hold;
      next_prdata[CTRL_TC_LSB +: 4]           = dc_loop_time_code;
      next_prdata[CTRL_PARALLEL]              = parallel_mode;
      next_prdata[CTRL_FMT_LSB +: NCH]        = channel_code_format;
      next_prdata[CTRL_DRIVE2X]               = diff_clock_drive_double;
      next_prdata[CTRL_HALT]                  = output_halt;
    end
    else if (paddr == ADDR_GAIN)
    begin
      next_prdata[3:0] = gain_code;
    end
    else if (paddr == ADDR_STATUS)
    begin
      next_prdata[STAT_OVF] = overflow;
      next_prdata[STAT_LVL_LSB +: $clog2(FIFO_DEPTH)+1] = fifo_level;
    end
    else if (paddr >= ADDR_EST0 && paddr <= ADDR_EST3 && paddr[1:0] == 2'h0)
    begin
      next_prdata = 32'($signed(est_bus[2'((paddr - ADDR_EST0) >> 2)]));
    end
    else
    begin
      next_pslverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & next_pslverr;
      if (setup)
      begin
        prdata <= pwrite ? '0 : next_prdata;
      end
    end
  end

  // Control registers; all start cleared so gain and loop are off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      digital_mode            <= 2'h0;
      dc_loop_enable          <= 1'b0;
      dc_loop_hold            <= 1'b0;
      dc_loop_time_code       <= 4'h0;
      parallel_mode           <= 1'b0;
      channel_code_format     <= '0;
      diff_clock_drive_double <= 1'b0;
      output_halt             <= 1'b0;
      gain_code               <= 4'h0;
    end
    else if (wr_en && paddr == ADDR_CTRL)
    begin
      digital_mode            <= {pwdata[CTRL_MODE2], pwdata[CTRL_MODE1]};
      dc_loop_enable          <= pwdata[CTRL_DC_EN];
      dc_loop_hold            <= pwdata[CTRL_DC_HOLD];
      dc_loop_time_code       <= pwdata[CTRL_TC_LSB +: 4];
      parallel_mode           <= pwdata[CTRL_PARALLEL];
      channel_code_format     <= pwdata[CTRL_FMT_LSB +: NCH];
      diff_clock_drive_double <= pwdata[CTRL_DRIVE2X];
      output_halt             <= pwdata[CTRL_HALT];
    end
    else if (wr_en && paddr == ADDR_GAIN)
    begin
      gain_code <= pwdata[3:0];
    end
  end

  // Overflow is sticky; a new drop in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      overflow <= 1'b0;
    end
    else if (proc_valid && !fifo_in_ready)
    begin
      overflow <= 1'b1;
    end
    else if (wr_en && paddr == ADDR_STATUS && pwdata[STAT_OVF])
    begin
      overflow <= 1'b0;
    end
  end
endmodule : adcb_backend

// ---- sim/adcb_backend_properties.sv ----
// Checker of output pin timing and bus answers for the back end
`timescale 1ns/1ps
module adcb_backend_properties (
  // Bus
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [adcb_pkg::AW-1:0]     paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic                        pready,
  // Pins
  input wire logic [adcb_pkg::WORD_W-1:0] out_data,
  input wire logic                        sample_output_clock,
  input wire logic                        output_parallel
);
  import adcb_pkg::*;
  logic ck;
  logic par;
  logic ctrl_wr;
  logic want_par;
  assign ck = sample_output_clock;
  assign par = output_parallel;
  assign ctrl_wr = psel && penable && pready && pwrite && paddr == ADDR_CTRL;
  // Last mode written, which the pins must reach by the next word boundary
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      want_par <= 1'b0;
    else if (ctrl_wr)
      want_par <= pwdata[CTRL_PARALLEL];
  end
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_ddr_clock;
    $rose(ck) && !par |=> ck ##1 !ck ##1 !ck;
  endproperty
  a_ddr_clock: assert property (p_ddr_clock)
    else $error("ddr output clock not two high then two low");
  property p_par_clock;
    $rose(ck) && par |=> ck ##1 (!ck || !par);
  endproperty
  a_par_clock: assert property (p_par_clock)
    else $error("parallel output clock high phase wrong");
  property p_ddr_upper;
    !par |-> out_data[WORD_W-1:PAIRS] == '0;
  endproperty
  a_ddr_upper: assert property (p_ddr_upper)
    else $error("unused pins driven in ddr mode");
  property p_par_hold;
    $rose(ck) && par |-> $stable(out_data) ##1 $stable(out_data);
  endproperty
  a_par_hold: assert property (p_par_hold)
    else $error("parallel data moved around capture edge");
  property p_edge_align;
    $changed(out_data) && $stable(par) |-> $changed(ck);
  endproperty
  a_edge_align: assert property (p_edge_align)
    else $error("data changed away from an output clock edge");
  property p_mode_hold;
    $changed(par) |=> $stable(par)[*3];
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode changed inside a word");
  property p_mode_follow;
    ctrl_wr |=> ##[0:4] (par == want_par);
  endproperty
  a_mode_follow: assert property (p_mode_follow)
    else $error("mode did not follow control write");
  property p_ready;
    psel && !penable |=> pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("bus answer missing in access cycle");
endmodule : adcb_backend_properties
bind adcb_backend adcb_backend_properties adcb_backend_properties_i (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .out_data, .sample_output_clock, .output_parallel);

// ---- sim/adcb_receiver.sv ----
// Capture receiver model for the back end output pins
`timescale 1ns/1ps
module adcb_receiver (
  // Clock
  input wire logic                        pclk,
  // Pins from the back end
  input wire logic [adcb_pkg::WORD_W-1:0] out_data,
  input wire logic                        sample_output_clock,
  input wire logic                        output_parallel,
  // Last captured word
  output logic [adcb_pkg::WORD_W-1:0]     word
);
  import adcb_pkg::*;
  logic             last_clk;
  logic [PAIRS-1:0] even_half;
  // Pins are sampled on the same pclk edge that launches them; nonblocking updates leave the old values visible
  always @(posedge pclk)
  begin
    last_clk <= sample_output_clock;
    if (sample_output_clock && !last_clk)
    begin
      if (output_parallel)
        word <= out_data;
      else
        even_half <= out_data[PAIRS-1:0];
    end
    if (!sample_output_clock && last_clk && !output_parallel)
      for (int k = 0; k < PAIRS; k++)
        word[2*k +: 2] <= {out_data[k], even_half[k]};
  end
endmodule : adcb_receiver

// ---- sim/adcb_backend_bench.sv ----
// Self-checking bench for the converter back end
`timescale 1ns/1ps
module adcb_backend_bench;
  import adcb_pkg::*;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [AW-1:0]        paddr;
  logic [31:0]          pwdata, prdata, rd, rng, ctrl;
  logic                 sample_clock, link_on, err;
  logic [RAW_BUS_W-1:0] core_sample, next_sample;
  logic [WORD_W-1:0]    out_data, word;
  logic                 sample_output_clock, output_parallel, diff_clock_drive_double;
  logic [3:0]           gain;
  int                   n_mismatch = 0;
  int                   num_checks = 0;
  int                   cycles = 0;
  adcb_backend adcb_backend_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sample_clock, .core_sample, .out_data, .sample_output_clock,
    .output_parallel, .diff_clock_drive_double);
  adcb_receiver adcb_receiver_i (.pclk, .out_data, .sample_output_clock, .output_parallel,
    .word);
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Sampling clock has an odd phase offset so it never lines up with pclk edges
  initial
  begin
    sample_clock = 1'b0;
    #137;
    forever #200 sample_clock = link_on ? ~sample_clock : 1'b0;
  end
  always @(negedge sample_clock)
    core_sample <= next_sample;
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic final_report();
    if (n_mismatch == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t register read %h expected %h", $time, got, exp);
    end
  endtask : check_reg
  task automatic check_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t captured word %h expected %h", $time, got, exp);
    end
  endtask : check_word
  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [WORD_W-1:0] exp_word(input logic [RAW_BUS_W-1:0] raw,
    input logic [31:0] c, input logic [3:0] g);
    logic [WORD_W-1:0] w;
    int                x;
    int                q;
    q = int'(GAIN_UNITY);
    if (c[CTRL_MODE1] && c[CTRL_MODE2])
      q = int'(GAIN_Q[g > GAIN_CODE_MAX ? GAIN_CODE_MAX : g]);
    for (int k = 0; k < NCH; k++)
    begin
      x = (int'($signed(raw[RW*k +: RW])) * q) >>> GAIN_SHIFT;
      x = x > int'(SAT_POS) ? int'(SAT_POS) : (x < int'(SAT_NEG) ? int'(SAT_NEG) : x);
      w[DW*k +: DW] = DW'(x) ^ {c[CTRL_FMT_LSB + k], 10'h000};
    end
    return w;
  endfunction : exp_word
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    core_sample = '0;
    next_sample = '0;
    link_on = 1'b1;
    rng = 32'h9E28;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_CTRL, '0);
    check_reg(rd, '0);
    apb(1'b0, ADDR_GAIN, '0);
    check_reg(rd, '0);
    apb(1'b0, 8'h40, '0);
    check_reg({rd[31:1], err}, 32'h1);
    // First three passes clip full scale and beyond, the rest are random settings
    for (int i = 0; i < 16; i++)
    begin
      rng = xs(rng);
      ctrl = i < 3 ? 32'h0000_0B03 : rng & 32'h0000_3F03;
      gain = i < 3 ? GAIN_CODE_MAX : rng[19:16];
      rng = xs(rng);
      case (i)
        0: next_sample = {4{12'h3FF}};
        1: next_sample = {4{12'hC00}};
        2: next_sample = {2{12'h7FF, 12'h800}};
        default: next_sample = {rng[15:0], xs(rng)};
      endcase
      apb(1'b1, ADDR_CTRL, ctrl);
      apb(1'b1, ADDR_GAIN, {28'h0, gain});
      apb(1'b0, ADDR_CTRL, '0);
      check_reg(rd, ctrl);
      check_reg({31'h0, diff_clock_drive_double}, {31'h0, ctrl[CTRL_DRIVE2X]});
      repeat (64) @(posedge pclk);
      check_word(word, exp_word(next_sample, ctrl, gain));
    end
    // Halted drain fills the buffer until it drops samples
    apb(1'b1, ADDR_CTRL, 32'h0000_4000);
    repeat (120) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, '0);
    check_reg(rd, 32'h0000_0011);
    link_on = 1'b0;
    apb(1'b1, ADDR_CTRL, '0);
    repeat (60) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, '0);
    check_reg(rd, 32'h0000_0001);
    apb(1'b1, ADDR_STATUS, 32'h1);
    apb(1'b0, ADDR_STATUS, '0);
    check_reg(rd, '0);
    link_on = 1'b1;
    // About 1125 ticks of 2000 at the shortest time constant leave an estimate of 2
    next_sample = {4{12'h7D0}};
    apb(1'b1, ADDR_GAIN, '0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0007);
    repeat (9000) @(posedge pclk);
    apb(1'b1, ADDR_CTRL, 32'h0000_000F);
    apb(1'b0, ADDR_EST0, '0);
    check_reg(rd, 32'h2);
    next_sample = {4{12'h064}};
    repeat (2000) @(posedge pclk);
    apb(1'b0, ADDR_EST3, '0);
    check_reg(rd, 32'h2);
    check_word(word, exp_word({4{12'h062}}, 32'h3, 4'h0));
    final_report();
  end
endmodule : adcb_backend_bench
